// file: verilog/dmba_defs.vh
// Purpose: constants for the data-memory bank addressing block
// Assumes: 8-bit data, 8-bit addresses, seven banks of general memory
// Notes:   bank 1 holds display memory up to DMBA_B1_LAST
`ifndef DMBA_DEFS_VH
`define DMBA_DEFS_VH
`define DMBA_A_IND0     8'h00
`define DMBA_A_PTR0     8'h01
`define DMBA_A_IND1     8'h02
`define DMBA_A_PTR1     8'h03
`define DMBA_A_BANK     8'h04
`define DMBA_A_ACC      8'h05
`define DMBA_SFR_LAST   8'h3f
`define DMBA_GP_FIRST   8'h40
`define DMBA_B1_LAST    8'h7f
`define DMBA_NBANKS     8'h07
`define DMBA_BANK1      8'h01
`define DMBA_ZERO       8'h00
`endif

// file: verilog/dmba_core.v
// Purpose: data memory address path with direct, indirect and banked access
// Assumes: core presents one access per cycle on the system clock
// Notes:   peripheral SFRs live outside; their read data on i_sfr_rdata is not used, so such reads return zero
`timescale 1ns/1ps
`include "dmba_defs.vh"

module dmba_core (
  input  wire       i_sys_clk,
  input  wire       i_nrst,
  input  wire       i_wdt_pd_rst,
  input  wire       i_rd,
  input  wire       i_wr,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_acc_load,
  input  wire [7:0] i_alu_result,
  input  wire [7:0] i_sfr_rdata,
  output reg        o_sfr_rd_ff,
  output reg        o_sfr_wr_ff,
  output reg  [7:0] o_sfr_addr_ff,
  output reg  [7:0] o_sfr_wdata_ff,
  output reg  [7:0] o_rdata_ff,
  output reg  [7:0] o_accumulator_ff,
  output reg  [7:0] o_bank_selector_ff
);

  reg  [7:0] pointer_bank0_ff;
  reg  [7:0] pointer_any_bank_ff;
  reg  [7:0] gp_mem [0:1791];
  reg        wdt_s2_ff;
  reg        wdt_meta_ff;
  reg        keep_bank_ff;

  // ==========================================================
  // Address resolution
  wire       via0   = (i_addr == `DMBA_A_IND0);
  wire       via1   = (i_addr == `DMBA_A_IND1);
  wire [7:0] eff_a  = via0 ? pointer_bank0_ff : (via1 ? pointer_any_bank_ff : i_addr);
  wire [7:0] eff_b  = via1 ? o_bank_selector_ff : `DMBA_ZERO;
  wire       to_ind = (via0 | via1) &&
                      (eff_a == `DMBA_A_IND0 || eff_a == `DMBA_A_IND1);
  wire       is_sfr = (eff_a <= `DMBA_SFR_LAST);
  wire       bank_ok = (eff_b < `DMBA_NBANKS);
  wire       b1_hole = (eff_b == `DMBA_BANK1) && (eff_a > `DMBA_B1_LAST);
  wire       gp_ok  = !is_sfr && bank_ok && !b1_hole;
  wire [10:0] gp_idx = {eff_b[2:0], eff_a} - {3'h0, `DMBA_GP_FIRST};
  wire       local_r = (eff_a == `DMBA_A_PTR0) || (eff_a == `DMBA_A_PTR1) ||
                       (eff_a == `DMBA_A_BANK) || (eff_a == `DMBA_A_ACC);
  reg  [7:0] nxt_local;

  always @* begin
    case (eff_a)
      `DMBA_A_PTR0: nxt_local = pointer_bank0_ff;
      `DMBA_A_PTR1: nxt_local = pointer_any_bank_ff;
      `DMBA_A_BANK: nxt_local = o_bank_selector_ff;
      `DMBA_A_ACC:  nxt_local = o_accumulator_ff;
      default:      nxt_local = `DMBA_ZERO;
    endcase
  end

  // ==========================================================
  // Access qualifiers
  // A port that points back at a port drops the whole access, so every
  // store enable and strobe below carries the to_ind guard.
  wire       wr_ok   = i_wr && !to_ind;
  wire       rd_ok   = i_rd && !to_ind;
  wire       wr_ptr0 = wr_ok && (eff_a == `DMBA_A_PTR0);
  wire       wr_ptr1 = wr_ok && (eff_a == `DMBA_A_PTR1);
  wire       wr_bank = wr_ok && (eff_a == `DMBA_A_BANK);
  wire       wr_acc  = wr_ok && (eff_a == `DMBA_A_ACC);
  wire       wr_gp   = wr_ok && gp_ok;
  wire       sfr_ext = is_sfr && !local_r;
  reg  [7:0] nxt_rdata;
  reg  [7:0] nxt_acc;
  reg  [7:0] nxt_bank;
  reg  [7:0] nxt_ptr0;
  reg  [7:0] nxt_ptr1;

  // ==========================================================
  // Read data selection
  // Peripheral read data is not muxed here, so a read of any SFR other
  // than the pointers, bank selector and accumulator returns zero.
  always @* begin
    nxt_rdata = o_rdata_ff;
    if (i_rd) begin
      if (to_ind)
        nxt_rdata = `DMBA_ZERO;
      else if (local_r)
        nxt_rdata = nxt_local;
      else if (is_sfr)
        nxt_rdata = `DMBA_ZERO;
      else if (gp_ok)
        nxt_rdata = gp_mem[gp_idx];
      else
        nxt_rdata = `DMBA_ZERO;
    end
  end

  // Register write wins over an ALU load in the same cycle
  always @* begin
    nxt_acc = o_accumulator_ff;
    if (wr_acc)
      nxt_acc = i_wdata;
    else if (i_acc_load)
      nxt_acc = i_alu_result;
  end

  always @* begin
    nxt_ptr0 = pointer_bank0_ff;
    if (wr_ptr0)
      nxt_ptr0 = i_wdata;
  end

  always @* begin
    nxt_ptr1 = pointer_any_bank_ff;
    if (wr_ptr1)
      nxt_ptr1 = i_wdata;
  end

  // Reset window clears, unless the strap says watchdog wake in power-down
  always @* begin
    nxt_bank = o_bank_selector_ff;
    if (keep_bank_ff) begin
      if (!wdt_s2_ff)
        nxt_bank = `DMBA_ZERO;
    end else if (wr_bank) begin
      nxt_bank = i_wdata;
    end
  end

  // ==========================================================
  // Watchdog power-down strap
  // No reset on this pair: it must go on sampling the strap while i_nrst
  // is low, or the bank would be cleared on every release.
  always @(posedge i_sys_clk) begin
    wdt_meta_ff <= i_wdt_pd_rst;
    wdt_s2_ff   <= wdt_meta_ff;
  end

  // High through reset and the first edge after release
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst)
      keep_bank_ff <= 1'b1;
    else
      keep_bank_ff <= 1'b0;
  end

  // ==========================================================
  // Bank selector
  // Left out of the async reset so a watchdog wake can keep it; the
  // bank is cleared on a clock edge, at the latest the first one after release.
  always @(posedge i_sys_clk) begin
    o_bank_selector_ff <= nxt_bank;
  end

  // ==========================================================
  // Pointers and accumulator
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pointer_bank0_ff <= `DMBA_ZERO;
    end else begin
      pointer_bank0_ff <= nxt_ptr0;
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pointer_any_bank_ff <= `DMBA_ZERO;
    end else begin
      pointer_any_bank_ff <= nxt_ptr1;
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_accumulator_ff <= `DMBA_ZERO;
    end else begin
      o_accumulator_ff <= nxt_acc;
    end
  end

  // ==========================================================
  // Read data and peripheral strobes
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata_ff <= `DMBA_ZERO;
    end else begin
      o_rdata_ff <= nxt_rdata;
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_rd_ff <= 1'b0;
    end else begin
      o_sfr_rd_ff <= rd_ok && sfr_ext;
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_wr_ff <= 1'b0;
    end else begin
      o_sfr_wr_ff <= wr_ok && sfr_ext;
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_addr_ff <= `DMBA_ZERO;
    end else begin
      o_sfr_addr_ff <= eff_a;
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_wdata_ff <= `DMBA_ZERO;
    end else begin
      o_sfr_wdata_ff <= i_wdata;
    end
  end

  // ==========================================================
  // General and display memory
  // Display memory is bank 1 of the same array, so only the second
  // pointer pair can reach it.
  always @(posedge i_sys_clk) begin
    if (wr_gp)
      gp_mem[gp_idx] <= i_wdata;
  end

endmodule

// file: sim/dmba_asserts.sv
// Purpose: timing checks. Assumes: one clock. Notes: sees top ports only.
`timescale 1ns/1ps
module dmba_asserts (
  input wire       i_sys_clk, i_nrst, i_rd, i_wr, i_acc_load,
  input wire [7:0] i_addr, i_wdata, i_alu_result, o_rdata_ff, o_accumulator_ff,
  input wire [7:0] o_bank_selector_ff
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_hole_zero: assert property (i_rd && i_addr > 8'h05 && i_addr < 8'h40
    |=> o_rdata_ff == 8'h00) else $error("hole read");
  a_ptr_readback: assert property (i_wr && i_addr == 8'h01 ##2 i_rd && i_addr == 8'h01
    |=> o_rdata_ff == $past(i_wdata, 3)) else $error("pointer read");
  a_bank_write: assert property (i_wr && i_addr == 8'h04 && i_wdata < 8'h07
    |=> o_bank_selector_ff == $past(i_wdata)) else $error("bank write");
  a_bank_steady: assert property ($past(i_nrst) && !(i_wr && i_addr == 8'h04)
    |=> $stable(o_bank_selector_ff)) else $error("bank moved");
  a_acc_alu: assert property (i_acc_load && !(i_wr && i_addr == 8'h05)
    |=> o_accumulator_ff == $past(i_alu_result)) else $error("alu load");
  a_acc_write: assert property (i_wr && i_addr == 8'h05
    |=> o_accumulator_ff == $past(i_wdata)) else $error("acc write");
  a_bank_read: assert property (i_rd && i_addr == 8'h04
    |=> o_rdata_ff == $past(o_bank_selector_ff)) else $error("bank read");
  a_acc_read: assert property (i_rd && i_addr == 8'h05
    |=> o_rdata_ff == $past(o_accumulator_ff)) else $error("acc read");
endmodule
bind dmba_core dmba_asserts u_dmba_asserts (.*);

// file: sim/dmba_core_model.sv
// Purpose: core access model. Assumes: one access per call. Notes: idles between calls.
`timescale 1ns/1ps
module dmba_core_model (
  input  wire       i_sys_clk,
  input  wire [7:0] o_rdata_ff,
  output reg        i_rd, i_wr,
  output reg  [7:0] i_addr, i_wdata, i_sfr_rdata
);
  initial {i_rd, i_wr, i_addr, i_wdata} = 18'h0;
  // Ignored peripheral data is never initialised and stays X, so a stray mux path shows up
  always @(posedge i_sys_clk) i_sfr_rdata <= (i_sfr_rdata == 8'hff) ? 8'h00 : 8'hff;
  task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    @(posedge i_sys_clk);
    #1 {i_rd, i_wr, i_addr, i_wdata} = {!w, w, a, d};
    @(posedge i_sys_clk);
    #1 {i_rd, i_wr} = 2'b00;
    q = o_rdata_ff;
  endtask
endmodule

// file: sim/data_memory_bank_addressing_bench.sv
// Purpose: bank addressing bench. Assumes: 25 MHz clock. Notes: checks on returned reads.
`timescale 1ns/1ps
module data_memory_bank_addressing_bench;
  reg        i_sys_clk = 1'b0, i_nrst = 1'b0, i_wdt_pd_rst = 1'b0, i_acc_load = 1'b0;
  reg  [7:0] i_alu_result = 8'h5a, q;
  wire       i_rd, i_wr;
  wire [7:0] i_addr, i_wdata, i_sfr_rdata, o_rdata_ff, o_accumulator_ff, o_bank_selector_ff;
  wire       o_sfr_rd_ff, o_sfr_wr_ff;
  wire [7:0] o_sfr_addr_ff, o_sfr_wdata_ff;
  integer    err_total = 0, check_count = 0;
  always #20 i_sys_clk = ~i_sys_clk;
  dmba_core u_dmba_core (.*);
  dmba_core_model u_dmba_core_model (.*);
  task chk(input [7:0] seen, input [7:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task w(input [7:0] a, input [7:0] d);
    u_dmba_core_model.acc(1'b1, a, d, q);
  endtask
  task r(input [7:0] a, input [7:0] e);
    u_dmba_core_model.acc(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // Watchdog-in-power-down flag stays up past release to cover its 2-stage sync
  task do_reset(input pd);
    i_wdt_pd_rst = pd;
    repeat (3) @(posedge i_sys_clk);
    #1 i_nrst = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    #1 i_nrst = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1 i_wdt_pd_rst = 1'b0;
  endtask
  task t_direct;
    w(8'h01, 8'h45);
    r(8'h01, 8'h45);
    w(8'h00, 8'ha5);
    r(8'h45, 8'ha5);
    w(8'h50, 8'h11);
  endtask
  task t_bank;
    w(8'h03, 8'h50);
    w(8'h04, 8'h01);
    r(8'h04, 8'h01);
    w(8'h02, 8'h3c);
    r(8'h02, 8'h3c);
    r(8'h50, 8'h11);
    w(8'h03, 8'h80);
    r(8'h02, 8'h00);
    w(8'h03, 8'h01);
    r(8'h02, 8'h45);
    w(8'h03, 8'h00);
    r(8'h02, 8'h00);
    w(8'h01, 8'h50);
    r(8'h01, 8'h50);
    r(8'h00, 8'h11);
    w(8'h04, 8'h07);
    w(8'h03, 8'h50);
    r(8'h02, 8'h00);
    r(8'h3c, 8'h00);
  endtask
  task t_acc;
    @(posedge i_sys_clk);
    #1 i_acc_load = 1'b1;
    @(posedge i_sys_clk);
    #1 i_acc_load = 1'b0;
    r(8'h05, 8'h5a);
    w(8'h05, 8'h33);
    chk(o_accumulator_ff, 8'h33);
  endtask
  task t_reset;
    w(8'h04, 8'h01);
    do_reset(1'b1);
    chk(o_bank_selector_ff, 8'h01);
    do_reset(1'b0);
    chk(o_bank_selector_ff, 8'h00);
  endtask
  task t_sfr;
    w(8'h04, 8'h01);
    w(8'h12, 8'h77);
    chk({7'h0, o_sfr_wr_ff}, 8'h01);
    chk(o_sfr_addr_ff, 8'h12);
    chk(o_sfr_wdata_ff, 8'h77);
    r(8'h12, 8'h00);
    chk({7'h0, o_sfr_rd_ff}, 8'h01);
    chk({7'h0, o_sfr_wr_ff}, 8'h00);
    w(8'h01, 8'h20);
    w(8'h00, 8'h99);
    chk(o_sfr_addr_ff, 8'h20);
    chk({7'h0, o_sfr_rd_ff}, 8'h00);
    @(posedge i_sys_clk);
    #1 chk({7'h0, o_sfr_wr_ff}, 8'h00);
  endtask
  task end_sim;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    t_direct;
    t_bank;
    t_acc;
    t_reset;
    t_sfr;
    end_sim;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    end_sim;
  end
endmodule
